// >>> timer_channel_status_irq.sv
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
// Overview of operation
// - compare C value is a read/write 16-bit field, upper bits read zero
// - capture mode: second load of A or B without read sets overrun
// - waveform mode: compare A match sets its flag; reads zero in capture
// - waveform mode: compare B match sets its flag; reads zero in capture
// - compare C match sets its flag in either mode
// - capture mode: capture A load sets its flag; zero in waveform
// - capture mode: capture B load sets its flag; zero in waveform
// - external trigger sets its flag in either mode
// - event flags stick until the status word is read, then clear
// - status bit 16 shows whether the counter clock runs, never cleared
// - status bit 17 echoes line A: pin in capture, drive in waveform
// - status bit 18 echoes line B: pin in capture, drive in waveform
// - flag bits: 0 overflow, 1 overrun, 2-4 compares, 5-6 loads, 7 trigger
// - enable port write-only; ones set enables, zeros leave them alone
// - counter overflow sets flag 0, enabled as interrupt by bit 0
// - disable port write-only; ones clear enables, zeros do nothing
// - mode bit zero selects capture mode, one selects waveform mode
module timer_channel_status_irq (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire timer_status_pkg::bus_req_t i_bus,
  output logic [timer_status_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_wave_mode,
  input wire timer_status_pkg::counter_events_t i_events,
  input wire logic i_capture_a_read,
  input wire logic i_capture_b_read,
  input wire logic i_clock_running,
  input wire timer_status_pkg::timer_lines_t i_lines,
  output logic [timer_status_pkg::CMP_W-1:0] o_compare_c_value,
  output logic o_irq
);
  import timer_status_pkg::*;

  logic [CMP_W-1:0] compare_c;
  logic [FLAG_W-1:0] flags;
  logic [FLAG_W-1:0] next_flags;
  logic [FLAG_W-1:0] raw_events;
  logic [FLAG_W-1:0] visible_flags;
  logic [FLAG_W-1:0] irq_enable;
  logic pending_a;
  logic pending_b;
  logic overrun_event;
  logic line_a_echo;
  logic line_b_echo;
  logic status_read;
  logic [DATA_W-1:0] status_word;
  logic compare_c_write;
  logic enable_write;
  logic disable_write;

  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] ofs,
                               input logic strobe);
    hit = strobe && (addr == ofs);
  endfunction

  assign status_read = hit(i_bus.addr, OFS_STATUS, i_bus.rd);
  // strobes decoded once so the checks below see sampled values
  assign compare_c_write = hit(i_bus.addr, OFS_COMPARE_C, i_bus.wr);
  assign enable_write = hit(i_bus.addr, OFS_IRQ_ENABLE, i_bus.wr);
  assign disable_write = hit(i_bus.addr, OFS_IRQ_DISABLE, i_bus.wr);

  // mode decides which flags may live; capture when the mode bit is 0
  function automatic logic [FLAG_W-1:0] mode_mask(input logic wave);
    mode_mask = wave ? ~CAPTURE_ONLY_FLAGS : ~WAVEFORM_ONLY_FLAGS;
  endfunction

  // a load while the previous one is unread is an overrun
  assign overrun_event = (i_events.load_a && pending_a) ||
                         (i_events.load_b && pending_b);

  always_comb begin
    raw_events = FLAGS_RESET;
    raw_events[BIT_OVERFLOW] = i_events.overflow;
    raw_events[BIT_LOAD_OVERRUN] = overrun_event;
    raw_events[BIT_COMPARE_A] = i_events.compare_a;
    raw_events[BIT_COMPARE_B] = i_events.compare_b;
    raw_events[BIT_COMPARE_C] = i_events.compare_c;
    raw_events[BIT_LOAD_A] = i_events.load_a;
    raw_events[BIT_LOAD_B] = i_events.load_b;
    raw_events[BIT_EXT_TRIGGER] = i_events.ext_trigger;
  end

  // an event in the clearing cycle survives the read
  always_comb begin
    next_flags = status_read ? FLAGS_RESET : flags;
    next_flags = next_flags | (raw_events & mode_mask(i_wave_mode));
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // flags of the other mode read zero even if set before a mode change
  assign visible_flags = flags & mode_mask(i_wave_mode);

  // pending marks a load not yet read; a status read restarts the window
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pending_a <= 1'b0;
      pending_b <= 1'b0;
    end else begin
      if (i_events.load_a && !i_wave_mode) begin
        pending_a <= 1'b1;
      end else if (i_capture_a_read || status_read) begin
        pending_a <= 1'b0;
      end
      if (i_events.load_b && !i_wave_mode) begin
        pending_b <= 1'b1;
      end else if (i_capture_b_read || status_read) begin
        pending_b <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      compare_c <= COMPARE_C_RESET;
    end else if (compare_c_write) begin
      compare_c <= i_bus.wdata[CMP_W-1:0];
    end
  end

  assign o_compare_c_value = compare_c;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      irq_enable <= ENABLE_RESET;
    end else if (enable_write) begin
      irq_enable <= irq_enable | i_bus.wdata[FLAG_W-1:0];
    end else if (disable_write) begin
      irq_enable <= irq_enable & ~i_bus.wdata[FLAG_W-1:0];
    end
  end

  // echo what the line really is: pin when sensing, drive when driving
  assign line_a_echo = i_wave_mode ? i_lines.line_a_drive
                                   : i_lines.line_a_pin;
  assign line_b_echo = i_wave_mode ? i_lines.line_b_drive
                                   : i_lines.line_b_pin;

  always_comb begin
    status_word = READ_IDLE;
    status_word[FLAG_W-1:0] = visible_flags;
    status_word[BIT_CLOCK_RUNNING] = i_clock_running;
    status_word[BIT_LINE_A_ECHO] = line_a_echo;
    status_word[BIT_LINE_B_ECHO] = line_b_echo;
  end

  // write-only ports read zero; mask readback exists for debug only
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= READ_IDLE;
    end else if (!i_bus.rd) begin
      o_rdata <= READ_IDLE;
    end else if (i_bus.addr == OFS_COMPARE_C) begin
      o_rdata <= {{(DATA_W-CMP_W){1'b0}}, compare_c};
    end else if (i_bus.addr == OFS_STATUS) begin
      o_rdata <= status_word;
    end else if (i_bus.addr == OFS_IRQ_MASK) begin
      o_rdata <= {{(DATA_W-FLAG_W){1'b0}}, irq_enable};
    end else begin
      o_rdata <= READ_IDLE;
    end
  end

  assign o_irq = |(visible_flags & irq_enable);

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  chk_compare_c_store: assert property (
    compare_c_write |=>
      o_compare_c_value == $past(i_bus.wdata[CMP_W-1:0]))
    else $error("compare C value not stored");

  chk_overrun_flag_set: assert property (
    !i_wave_mode && i_events.load_a && pending_a |=>
      flags[BIT_LOAD_OVERRUN])
    else $error("overrun not flagged on double load");

  chk_compare_a_wave: assert property (
    i_wave_mode && i_events.compare_a ##1 i_wave_mode |->
      visible_flags[BIT_COMPARE_A])
    else $error("compare A hit lost in waveform mode");

  chk_compare_b_capture: assert property (
    status_read && !i_wave_mode |=> !o_rdata[BIT_COMPARE_B])
    else $error("compare B visible in capture mode");

  chk_compare_c_any: assert property (
    i_events.compare_c |=> flags[BIT_COMPARE_C])
    else $error("compare C hit lost");

  chk_load_a_capture: assert property (
    !i_wave_mode && i_events.load_a |=> flags[BIT_LOAD_A])
    else $error("capture A load flag lost");

  chk_load_b_wave_zero: assert property (
    status_read && i_wave_mode |=> !o_rdata[BIT_LOAD_B])
    else $error("capture B load visible in waveform mode");

  chk_ext_trigger_set: assert property (
    i_events.ext_trigger |=> flags[BIT_EXT_TRIGGER])
    else $error("external trigger flag lost");

  chk_read_then_clear: assert property (
    status_read && raw_events == FLAGS_RESET |=>
      o_rdata[FLAG_W-1:0] == $past(visible_flags) && flags == FLAGS_RESET)
    else $error("status read did not return then clear");

  chk_clock_running_bit: assert property (
    status_read |=> o_rdata[BIT_CLOCK_RUNNING] == $past(i_clock_running))
    else $error("clock running bit wrong");

  chk_line_a_echo: assert property (
    status_read && !i_wave_mode |=>
      o_rdata[BIT_LINE_A_ECHO] == $past(i_lines.line_a_pin))
    else $error("line A echo wrong in capture mode");

  chk_line_b_echo: assert property (
    status_read && i_wave_mode |=>
      o_rdata[BIT_LINE_B_ECHO] == $past(i_lines.line_b_drive))
    else $error("line B echo wrong in waveform mode");

  chk_enable_set_only: assert property (
    enable_write |=>
      irq_enable == ($past(irq_enable) | $past(i_bus.wdata[FLAG_W-1:0])))
    else $error("enable write changed wrong bits");

  chk_disable_clear_only: assert property (
    disable_write |=>
      irq_enable == ($past(irq_enable) & ~$past(i_bus.wdata[FLAG_W-1:0])))
    else $error("disable write changed wrong bits");

  chk_overflow_irq: assert property (
    i_events.overflow && irq_enable[BIT_OVERFLOW] &&
      !disable_write |=> o_irq)
    else $error("overflow interrupt not raised");

  chk_irq_drops: assert property (
    o_irq && status_read && raw_events == FLAGS_RESET |=> !o_irq)
    else $error("interrupt held after flags cleared");

  chk_compare_c_hold: assert property (
    !compare_c_write |=> $stable(o_compare_c_value))
    else $error("compare C value changed without write");

  chk_compare_c_read: assert property (
    i_bus.rd && i_bus.addr == OFS_COMPARE_C |=>
      o_rdata == {{(DATA_W-CMP_W){1'b0}}, $past(o_compare_c_value)})
    else $error("compare C readback wrong");

  chk_overrun_b_set: assert property (
    !i_wave_mode && i_events.load_b && pending_b |=>
      flags[BIT_LOAD_OVERRUN])
    else $error("overrun not flagged on double load B");

  chk_overrun_wave_zero: assert property (
    status_read && i_wave_mode |=> !o_rdata[BIT_LOAD_OVERRUN])
    else $error("overrun visible in waveform mode");

  chk_pending_a_restart: assert property (
    status_read && !i_events.load_a |=> !pending_a)
    else $error("status read kept load A pending");

  chk_pending_b_restart: assert property (
    status_read && !i_events.load_b |=> !pending_b)
    else $error("status read kept load B pending");

  chk_reg_a_read: assert property (
    i_capture_a_read && !i_events.load_a |=> !pending_a)
    else $error("capture A read kept load pending");

  chk_reg_b_read: assert property (
    i_capture_b_read && !i_events.load_b |=> !pending_b)
    else $error("capture B read kept load pending");

  chk_single_load_ok: assert property (
    !i_wave_mode && i_events.load_a && !pending_a && !i_events.load_b &&
      !flags[BIT_LOAD_OVERRUN] |=> !flags[BIT_LOAD_OVERRUN])
    else $error("overrun flagged on a single load");

  chk_compare_a_capture: assert property (
    status_read && !i_wave_mode |=> !o_rdata[BIT_COMPARE_A])
    else $error("compare A visible in capture mode");

  chk_compare_b_wave: assert property (
    i_wave_mode && i_events.compare_b ##1 i_wave_mode |->
      visible_flags[BIT_COMPARE_B])
    else $error("compare B hit lost in waveform mode");

  chk_compare_c_capture: assert property (
    !i_wave_mode && i_events.compare_c |=> visible_flags[BIT_COMPARE_C])
    else $error("compare C hit lost in capture mode");

  chk_load_a_wave: assert property (
    status_read && i_wave_mode |=> !o_rdata[BIT_LOAD_A])
    else $error("capture A load visible in waveform mode");

  chk_load_b_capture: assert property (
    !i_wave_mode && i_events.load_b |=> flags[BIT_LOAD_B])
    else $error("capture B load flag lost");

  chk_trigger_any_mode: assert property (
    i_events.ext_trigger |=> visible_flags[BIT_EXT_TRIGGER])
    else $error("external trigger flag hidden");

  chk_flags_sticky: assert property (
    !status_read |=> (flags & $past(flags)) == $past(flags))
    else $error("event flag cleared without status read");

  chk_flags_quiet: assert property (
    !status_read && raw_events == FLAGS_RESET |=> $stable(flags))
    else $error("event flag set without event");

  chk_line_a_drive: assert property (
    status_read && i_wave_mode |=>
      o_rdata[BIT_LINE_A_ECHO] == $past(i_lines.line_a_drive))
    else $error("line A echo wrong in waveform mode");

  chk_line_b_pin: assert property (
    status_read && !i_wave_mode |=>
      o_rdata[BIT_LINE_B_ECHO] == $past(i_lines.line_b_pin))
    else $error("line B echo wrong in capture mode");

  chk_status_reserved: assert property (
    status_read |=> o_rdata[DATA_W-1:BIT_LINE_B_ECHO+1] == '0 &&
      o_rdata[BIT_CLOCK_RUNNING-1:FLAG_W] == '0)
    else $error("reserved status bits not zero");

  chk_trigger_bit_pos: assert property (
    status_read && flags[BIT_EXT_TRIGGER] |=> o_rdata[BIT_EXT_TRIGGER])
    else $error("trigger flag read at wrong position");

  chk_enable_hold: assert property (
    !enable_write && !disable_write |=> $stable(irq_enable))
    else $error("enables changed without a write");

  chk_enable_reads_zero: assert property (
    i_bus.rd && i_bus.addr == OFS_IRQ_ENABLE |=> o_rdata == READ_IDLE)
    else $error("enable port not write-only");

  chk_disable_reads_zero: assert property (
    i_bus.rd && i_bus.addr == OFS_IRQ_DISABLE |=> o_rdata == READ_IDLE)
    else $error("disable port not write-only");

  chk_overflow_flag_set: assert property (
    i_events.overflow |=> visible_flags[BIT_OVERFLOW])
    else $error("overflow flag lost");

  chk_capture_gates_read: assert property (
    status_read && !i_wave_mode |=>
      (o_rdata[FLAG_W-1:0] & WAVEFORM_ONLY_FLAGS) == FLAGS_RESET)
    else $error("waveform flags visible in capture mode");

  chk_wave_gates_read: assert property (
    status_read && i_wave_mode |=>
      (o_rdata[FLAG_W-1:0] & CAPTURE_ONLY_FLAGS) == FLAGS_RESET)
    else $error("capture flags visible in waveform mode");

  chk_irq_needs_enable: assert property (
    !(|irq_enable) |-> !o_irq)
    else $error("interrupt raised with no source enabled");

  chk_irq_on_trigger: assert property (
    i_events.ext_trigger && irq_enable[BIT_EXT_TRIGGER] &&
      !disable_write |=> o_irq)
    else $error("trigger interrupt not raised");

  chk_irq_mode_gated: assert property (
    i_wave_mode &&
      !(|(flags & irq_enable & ~CAPTURE_ONLY_FLAGS)) |-> !o_irq)
    else $error("hidden capture flag raised interrupt");

endmodule // timer_channel_status_irq

// >>> timer_status_pkg.sv
package timer_status_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 8;
  localparam int CMP_W = 16;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_COMPARE_C = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_DISABLE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h10;

  // event flag positions, shared by status and enable ports
  localparam int BIT_OVERFLOW = 0;
  localparam int BIT_LOAD_OVERRUN = 1;
  localparam int BIT_COMPARE_A = 2;
  localparam int BIT_COMPARE_B = 3;
  localparam int BIT_COMPARE_C = 4;
  localparam int BIT_LOAD_A = 5;
  localparam int BIT_LOAD_B = 6;
  localparam int BIT_EXT_TRIGGER = 7;

  // live status positions
  localparam int BIT_CLOCK_RUNNING = 16;
  localparam int BIT_LINE_A_ECHO = 17;
  localparam int BIT_LINE_B_ECHO = 18;

  // flags that only exist in one mode
  localparam logic [FLAG_W-1:0] CAPTURE_ONLY_FLAGS = 8'h62;
  localparam logic [FLAG_W-1:0] WAVEFORM_ONLY_FLAGS = 8'h0C;

  localparam logic [CMP_W-1:0] COMPARE_C_RESET = 16'h0000;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;
  localparam logic [FLAG_W-1:0] ENABLE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic overflow;
    logic compare_a;
    logic compare_b;
    logic compare_c;
    logic load_a;
    logic load_b;
    logic ext_trigger;
  } counter_events_t;

  typedef struct packed {
    logic line_a_pin;
    logic line_b_pin;
    logic line_a_drive;
    logic line_b_drive;
  } timer_lines_t;

endpackage

// >>> timer_channel_status_irq_tb.sv
`timescale 1ns/10ps
module timer_channel_status_irq_tb;
  import timer_status_pkg::*;

  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  bus_req_t bus = '0;
  logic [DATA_W-1:0] rdata;
  logic wave = 1'b1;
  counter_events_t ev = '0;
  logic cap_a_rd = 1'b0;
  logic cap_b_rd = 1'b0;
  logic clk_run = 1'b1;
  // pin a low, pin b high, drive a high, drive b low
  timer_lines_t lines = 4'h6;
  logic [CMP_W-1:0] cmp_c;
  logic irq;
  int err_count = 0;
  int samples_checked = 0;

  always #50 i_clk_sys = ~i_clk_sys;

  timer_channel_status_irq dut (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_bus(bus),
    .o_rdata(rdata),
    .i_wave_mode(wave),
    .i_events(ev),
    .i_capture_a_read(cap_a_rd),
    .i_capture_b_read(cap_b_rd),
    .i_clock_running(clk_run),
    .i_lines(lines),
    .o_compare_c_value(cmp_c),
    .o_irq(irq)
  );

  task automatic chk_word(input logic [DATA_W-1:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    bus.wr <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge i_clk_sys);
    bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    bus.rd <= 1'b0;
    #1 chk_word(rdata, e);
  endtask

  task automatic pulse(input logic [6:0] v);
    @(posedge i_clk_sys);
    ev <= counter_events_t'(v);
    @(posedge i_clk_sys);
    ev <= '0;
    #1;
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // no wait below is open-ended, this only guards a stuck run
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    err_count++;
    end_of_test;
  end

  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd(OFS_COMPARE_C, 32'h0000_0000);
    chk_bit(irq, 1'b0);
    wr(OFS_COMPARE_C, 32'hFFFF_ABCD);
    rd(OFS_COMPARE_C, 32'h0000_ABCD);
    chk_word({16'h0000, cmp_c}, 32'h0000_ABCD);
    @(posedge i_clk_sys);
    #1 chk_word(rdata, 32'h0000_0000);
    // waveform mode: all events at once, loads must be dropped
    pulse(7'h7F);
    rd(OFS_STATUS, 32'h0003_009D);
    rd(OFS_STATUS, 32'h0003_0000);
    pulse(7'h20);
    @(posedge i_clk_sys);
    wave <= 1'b0;
    rd(OFS_STATUS, 32'h0005_0000);
    // capture mode: compares a and b must be dropped
    pulse(7'h7F);
    rd(OFS_STATUS, 32'h0005_00F1);
    pulse(7'h02);
    pulse(7'h02);
    rd(OFS_STATUS, 32'h0005_0042);
    pulse(7'h04);
    @(posedge i_clk_sys);
    cap_a_rd <= 1'b1;
    @(posedge i_clk_sys);
    cap_a_rd <= 1'b0;
    pulse(7'h04);
    rd(OFS_STATUS, 32'h0005_0020);
    pulse(7'h02);
    @(posedge i_clk_sys);
    cap_b_rd <= 1'b1;
    @(posedge i_clk_sys);
    cap_b_rd <= 1'b0;
    pulse(7'h02);
    rd(OFS_STATUS, 32'h0005_0040);
    // interrupt enables: set, accumulate, disable
    wr(OFS_IRQ_ENABLE, 32'h0000_0001);
    pulse(7'h40);
    chk_bit(irq, 1'b1);
    rd(OFS_IRQ_ENABLE, 32'h0000_0000);
    wr(OFS_IRQ_ENABLE, 32'h0000_0080);
    rd(OFS_IRQ_MASK, 32'h0000_0081);
    wr(OFS_IRQ_DISABLE, 32'h0000_0001);
    chk_bit(irq, 1'b0);
    wr(OFS_IRQ_DISABLE, 32'h0000_0000);
    rd(OFS_IRQ_MASK, 32'h0000_0080);
    rd(OFS_IRQ_DISABLE, 32'h0000_0000);
    // status is not writable, clock bit is live
    wr(OFS_STATUS, 32'h0000_00FF);
    @(posedge i_clk_sys);
    clk_run <= 1'b0;
    rd(OFS_STATUS, 32'h0004_0001);
    rd(8'h20, 32'h0000_0000);
    pulse(7'h01);
    chk_bit(irq, 1'b1);
    rd(OFS_STATUS, 32'h0004_0080);
    chk_bit(irq, 1'b0);
    end_of_test;
  end
endmodule // timer_channel_status_irq_tb
